// ===== rtl/cac_device.sv
// Controller end: command acceptance, rejection windows and status reporting
`timescale 1ns/1ps
`include "cac_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Accept raises interrupt at least 5.5 us before request
// - Request flag means parameter, result, or waiting
// - Reject leaves interrupt low at request flag
// - Host checks interrupt level, rewrites if low
// - Status 00 in window means accepted
// - Status 10: busy at check decides acceptance
// - Rejected command shows busy clear after check
// - Half-accepted command keeps busy clear
// - Abort method: abort then reissue command
// - Sleep only uses interrupt-level method
// - Abort is accepted at all times
// - Ready change opens rejection window, doubled 5-inch
// - Half period accepts, busy waits first parameter
// - Ready change while pending rejects 20 us
module cac_device (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mode_5in,
  input wire logic ready_change,
  input wire logic seek_done,
  cac_link_if.device link,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_param,
  output logic sleep_req
);

  localparam int W = `CAC_TW;
  localparam logic [W-1:0] ONE = W'(1);
  localparam logic [W-1:0] LEAD_C = W'(`CAC_CYC_UP(`CAC_IRQ_LEAD_NS));
  localparam logic [W-1:0] ARM_C = W'(`CAC_CYC_UP(`CAC_ARM_NS));
  localparam logic [W-1:0] A1_C = W'(`CAC_CYC_UP(`CAC_ARM_NS + `CAC_AFTER_NS));
  localparam logic [W-1:0] A2_C = W'(`CAC_CYC_UP(`CAC_LONG_NS));
  localparam logic [W-1:0] B_C = W'(`CAC_CYC_UP(`CAC_HALF_NS));
  localparam logic [W-1:0] T2_C = W'(`CAC_CYC_UP(`CAC_T2_NS));
  localparam logic [W-1:0] HOLD_C = W'(`CAC_CYC_DN(`CAC_CHECK_NS));

  // Doubled counts must still fit the timers
  if (2 * `CAC_CYC_UP(`CAC_LONG_NS) >= (1 << W)) begin : g_width_chk
    $error("timer width too small for 5-inch counts");
  end
  if (T2_C < LEAD_C) begin : g_lead_chk
    $error("sample window shorter than interrupt lead");
  end

  cac_pkg::cac_dev_s r;
  cac_pkg::cac_dev_s n;
  logic wr_cmd;
  logic wr_par;
  logic is_abort;
  logic in_a;
  logic in_b;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [W-1:0] dbl(input logic m5, input logic [W-1:0] c);
    dbl = m5 ? {c[W-2:0], 1'b0} : c;
  endfunction

  function automatic logic [7:0] stat_of(input cac_pkg::cac_dev_state_e s,
                                         input logic half);
    case (s)
      cac_pkg::CAC_D_IDLE: stat_of = `CAC_STAT_WAIT;
      cac_pkg::CAC_D_SAMPLE: stat_of = half ? `CAC_STAT_HALF : `CAC_STAT_BUSY;
      cac_pkg::CAC_D_PARAM: stat_of = half ? `CAC_STAT_WAIT : `CAC_STAT_PARAM;
      cac_pkg::CAC_D_REJ: stat_of = `CAC_STAT_BUSY;
      cac_pkg::CAC_D_REJ_HOLD: stat_of = `CAC_STAT_PARAM;
      default: stat_of = `CAC_STAT_WAIT;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.cmd_valid = 1'b0;
    n.sleep_req = 1'b0;
    n.m_s1 = mode_5in;
    n.m_s2 = r.m_s1;
    wr_cmd = link.wr_strb & ~link.wr_is_param;
    wr_par = link.wr_strb & link.wr_is_param;
    is_abort = (link.wdata == `CAC_ABORT_CODE);
    in_a = (r.a_cnt != '0);
    in_b = (r.b_cnt != '0);

    // half period follows the rejection window
    if (in_a) begin
      n.a_cnt = r.a_cnt - ONE;
      if (r.a_cnt == ONE) begin
        n.b_cnt = dbl(r.m_s2, B_C);
      end
    end else if (in_b) begin
      n.b_cnt = r.b_cnt - ONE;
    end
    if (r.tmr != '0) begin
      n.tmr = r.tmr - ONE;
    end

    case (r.st)
      cac_pkg::CAC_D_SAMPLE: begin
        if (r.tmr == ONE) begin
          // request flag rises once the window ends
          if (r.code == `CAC_ABORT_CODE || r.code == `CAC_SLEEP_CODE) begin
            n.st = cac_pkg::CAC_D_IDLE;
            n.half = 1'b0;
            n.cmd_valid = 1'b1;
            n.sleep_req = (r.code == `CAC_SLEEP_CODE);
          end else begin
            n.st = cac_pkg::CAC_D_PARAM;
          end
        end
      end
      cac_pkg::CAC_D_PARAM: begin
        // busy would set on this first parameter
        if (wr_par) begin
          n.param = link.wdata;
          n.cmd_valid = 1'b1;
          n.half = 1'b0;
          n.st = cac_pkg::CAC_D_IDLE;
        end
      end
      cac_pkg::CAC_D_REJ: begin
        if (r.tmr == ONE) begin
          n.st = cac_pkg::CAC_D_REJ_HOLD;
          n.tmr = dbl(r.m_s2, HOLD_C);
        end
      end
      cac_pkg::CAC_D_REJ_HOLD: begin
        // busy drops one check time after request
        if (r.tmr == ONE) begin
          n.st = cac_pkg::CAC_D_IDLE;
        end
      end
      cac_pkg::CAC_D_IDLE: begin
        n.half = 1'b0;
      end
      default: begin
        n.st = cac_pkg::CAC_D_IDLE;
      end
    endcase

    // abort taken in any state and any window
    if (wr_cmd && (r.st == cac_pkg::CAC_D_IDLE || is_abort)) begin
      n.tmr = dbl(r.m_s2, T2_C);
      // reject non-abort codes inside the window
      if (in_a && !is_abort) begin
        n.st = cac_pkg::CAC_D_REJ;
      end else begin
        n.st = cac_pkg::CAC_D_SAMPLE;
        n.code = link.wdata;
        n.half = in_b && !is_abort;
        // interrupt released a full window before request
        n.pend = 1'b0;
      end
    end

    // Interrupt sources applied last so a set beats the clear
    if (r.arm_cnt != '0) begin
      n.arm_cnt = r.arm_cnt - ONE;
      if (r.arm_cnt == ONE) begin
        n.pend = 1'b1;
      end
    end
    if (ready_change) begin
      n.b_cnt = '0;
      if (r.pend) begin
        n.a_cnt = dbl(r.m_s2, A2_C);
      end else begin
        // window opens before the interrupt asserts
        n.a_cnt = dbl(r.m_s2, A1_C);
        n.arm_cnt = dbl(r.m_s2, ARM_C);
      end
    end
    if (seek_done) begin
      n.pend = 1'b1;
    end
    // a rejected code leaves the interrupt low
    n.irq_n = ~n.pend;
    n.stat = stat_of(n.st, n.half);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{st: cac_pkg::CAC_D_IDLE, stat: `CAC_STAT_WAIT, irq_n: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.main_status_value = r.stat;
  assign link.irq_n = r.irq_n;
  assign cmd_valid = r.cmd_valid;
  assign cmd_code = r.code;
  assign cmd_param = r.param;
  assign sleep_req = r.sleep_req;

endmodule

// ===== rtl/cac_host.sv
// Host end: issues commands, detects rejection and retries, AXI4-Lite controlled
`timescale 1ns/1ps
`include "cac_map.svh"

module cac_host (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mode_5in,
  cac_link_if.host link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic irq
);

  localparam int W = `CAC_TW;
  localparam logic [W-1:0] ONE = W'(1);
  localparam logic [W-1:0] CHK_C = W'(`CAC_CYC_UP(`CAC_CHECK_NS));
  localparam logic [W-1:0] SAMP_C = W'(2);

  cac_pkg::cac_host_s r;
  cac_pkg::cac_host_s n;
  logic [31:0] ctrl_w;
  logic ok_done;
  logic retry;
  logic st_busy;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic mapped(input logic [7:0] a, input logic wr);
    case (a)
      `CAC_REG_CTRL, `CAC_REG_INT_CLR: mapped = wr;
      `CAC_REG_STATUS, `CAC_REG_INT_STAT: mapped = !wr;
      `CAC_REG_INT_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] lanes(input logic [31:0] d, input logic [3:0] s);
    lanes = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.m_s1 = mode_5in;
    n.m_s2 = r.m_s1;
    n.wr_strb = 1'b0;
    n.wr_is_param = 1'b0;
    ok_done = 1'b0;
    retry = 1'b0;
    ctrl_w = lanes(r.w_data, r.w_strb);
    st_busy = link.main_status_value[`CAC_BSY_BIT];

    // AXI4-Lite write: address and data in either order
    if (s_axi_awvalid && r.awready) begin
      n.aw_full = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_full = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_full && r.w_full && !r.bvalid) begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = mapped(r.aw_addr, 1'b1) ? `CAC_RESP_OKAY : `CAC_RESP_SLVERR;
      if (r.aw_addr == `CAC_REG_CTRL && ctrl_w[`CAC_CTRL_GO_BIT]
          && r.st == cac_pkg::CAC_H_IDLE) begin
        n.code = ctrl_w[`CAC_CTRL_CODE_LSB +: 8];
        n.param = ctrl_w[`CAC_CTRL_PARAM_LSB +: 8];
        n.method = cac_pkg::cac_method_e'(ctrl_w[`CAC_CTRL_METHOD_LSB +: 2]);
        if (ctrl_w[`CAC_CTRL_CODE_LSB +: 8] == `CAC_SLEEP_CODE
            || ctrl_w[`CAC_CTRL_METHOD_LSB +: 2] == 2'b11) begin
          n.method = cac_pkg::CAC_M_IRQ;
        end
        n.retries = '0;
        n.send_abort = 1'b0;
        n.st = cac_pkg::CAC_H_READY;
      end
      if (r.aw_addr == `CAC_REG_INT_EN) begin
        n.int_en = ctrl_w[1:0];
      end
    end
    n.awready = !n.aw_full && !n.bvalid;
    n.wready = !n.w_full && !n.bvalid;

    // AXI4-Lite read, one under way at a time
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = mapped(s_axi_araddr, 1'b0) ? `CAC_RESP_OKAY : `CAC_RESP_SLVERR;
      case (s_axi_araddr)
        `CAC_REG_STATUS:
          n.rdata = {8'h00, link.main_status_value, r.retries, 7'h00,
                     r.st != cac_pkg::CAC_H_IDLE};
        `CAC_REG_INT_STAT: n.rdata = {30'h0, r.int_stat};
        `CAC_REG_INT_EN: n.rdata = {30'h0, r.int_en};
        default: n.rdata = 32'h0;
      endcase
    end
    n.arready = !n.rvalid;

    ////////////////////////////////////////////////////////////////////////
    if (r.tmr != '0) begin
      n.tmr = r.tmr - ONE;
    end
    case (r.st)
      cac_pkg::CAC_H_READY: begin
        // Write only when the controller waits for a command
        if (link.main_status_value == `CAC_STAT_WAIT) begin
          n.wr_strb = 1'b1;
          n.wdata = r.send_abort ? `CAC_ABORT_CODE : r.code;
          n.tmr = SAMP_C;
          n.st = cac_pkg::CAC_H_SAMP;
        end
      end
      cac_pkg::CAC_H_SAMP: begin
        if (r.tmr == ONE) begin
          // status 00 in the window means accepted
          n.half = (link.main_status_value == `CAC_STAT_HALF);
          n.send_abort = 1'b0;
          n.st = r.send_abort ? cac_pkg::CAC_H_READY : cac_pkg::CAC_H_WTXR;
        end
      end
      cac_pkg::CAC_H_WTXR: begin
        if (link.main_status_value[`CAC_TXR_BIT]) begin
          case (r.method)
            // interrupt level decides after request flag
            cac_pkg::CAC_M_IRQ: begin
              ok_done = link.irq_n;
              retry = !link.irq_n;
            end
            cac_pkg::CAC_M_STR: begin
              ok_done = r.half;
              if (!r.half) begin
                // check delay scaled by drive mode
                n.tmr = r.m_s2 ? {CHK_C[W-2:0], 1'b0} : CHK_C;
                n.st = cac_pkg::CAC_H_CHK;
              end
            end
            default: begin
              n.tmr = r.m_s2 ? {CHK_C[W-2:0], 1'b0} : CHK_C;
              n.st = cac_pkg::CAC_H_CHK;
            end
          endcase
        end
      end
      cac_pkg::CAC_H_CHK: begin
        if (r.tmr == ONE) begin
          // busy set at check time means accepted
          ok_done = st_busy;
          retry = !st_busy;
          // abort first, then the original code
          n.send_abort = !st_busy && r.method == cac_pkg::CAC_M_ABORT;
        end
      end
      cac_pkg::CAC_H_PARAM: begin
        n.wr_strb = 1'b1;
        n.wr_is_param = 1'b1;
        n.wdata = r.param;
        n.st = cac_pkg::CAC_H_IDLE;
        n.int_stat[`CAC_INT_DONE_BIT] = 1'b1;
      end
      cac_pkg::CAC_H_IDLE: begin
        n.half = 1'b0;
      end
      default: begin
        n.st = cac_pkg::CAC_H_IDLE;
      end
    endcase
    if (ok_done) begin
      if (r.code == `CAC_ABORT_CODE || r.code == `CAC_SLEEP_CODE) begin
        n.st = cac_pkg::CAC_H_IDLE;
        n.int_stat[`CAC_INT_DONE_BIT] = 1'b1;
      end else begin
        n.st = cac_pkg::CAC_H_PARAM;
      end
    end
    if (retry) begin
      n.retries = r.retries + 8'h01;
      n.st = cac_pkg::CAC_H_READY;
    end

    // Clear first, then events, so a same-cycle event survives
    if (r.aw_full && r.w_full && !r.bvalid && r.aw_addr == `CAC_REG_INT_CLR) begin
      n.int_stat = n.int_stat & ~ctrl_w[1:0] | (r.st == cac_pkg::CAC_H_PARAM ? 2'b01 : 2'b00);
    end
    if (retry) begin
      n.int_stat[`CAC_INT_REJ_BIT] = 1'b1;
    end
    if (ok_done && (r.code == `CAC_ABORT_CODE || r.code == `CAC_SLEEP_CODE)) begin
      n.int_stat[`CAC_INT_DONE_BIT] = 1'b1;
    end
    n.irq = |(n.int_stat & n.int_en);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{st: cac_pkg::CAC_H_IDLE, method: cac_pkg::CAC_M_IRQ,
             int_en: `CAC_INT_EN_RESET, default: '0};
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.wr_strb = r.wr_strb;
  assign link.wr_is_param = r.wr_is_param;
  assign link.wdata = r.wdata;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign irq = r.irq;

endmodule

// ===== rtl/cac_link_if.sv
// Link between the controller's host port and the host-side sequencer
`timescale 1ns/1ps
interface cac_link_if (
  input wire logic clk
);
  logic wr_strb;
  logic wr_is_param;
  logic [7:0] wdata;
  logic [7:0] main_status_value;
  logic irq_n;

  modport device (
    input clk,
    input wr_strb,
    input wr_is_param,
    input wdata,
    output main_status_value,
    output irq_n
  );

  modport host (
    input clk,
    output wr_strb,
    output wr_is_param,
    output wdata,
    input main_status_value,
    input irq_n
  );
endinterface

// ===== rtl/cac_map.svh
// Offsets, field positions, reset values and timing counts for the command acceptance link
`ifndef CAC_MAP_SVH
`define CAC_MAP_SVH

`define CAC_CLK_NS 40
`define CAC_TW 11
`define CAC_CYC_UP(ns) (((ns) + `CAC_CLK_NS - 1) / `CAC_CLK_NS)
`define CAC_CYC_DN(ns) ((ns) / `CAC_CLK_NS)

// Times in ns, 8-inch figures; 5-inch doubles them
`define CAC_IRQ_LEAD_NS 5500
`define CAC_ARM_NS 2250
`define CAC_AFTER_NS 1750
`define CAC_HALF_NS 500
`define CAC_LONG_NS 20000
`define CAC_T2_NS 9500
`define CAC_CHECK_NS 600

// Main status value fields and values
`define CAC_TXR_BIT 7
`define CAC_BSY_BIT 4
`define CAC_STAT_WAIT 8'h80
`define CAC_STAT_PARAM 8'h90
`define CAC_STAT_BUSY 8'h10
`define CAC_STAT_HALF 8'h00

// Command codes, arbitrary values
`define CAC_ABORT_CODE 8'hff
`define CAC_SLEEP_CODE 8'h0e

// Host end registers on AXI4-Lite
`define CAC_REG_CTRL 8'h00
`define CAC_REG_STATUS 8'h04
`define CAC_REG_INT_STAT 8'h08
`define CAC_REG_INT_CLR 8'h0c
`define CAC_REG_INT_EN 8'h10
`define CAC_CTRL_CODE_LSB 0
`define CAC_CTRL_PARAM_LSB 8
`define CAC_CTRL_METHOD_LSB 16
`define CAC_CTRL_GO_BIT 31
`define CAC_INT_DONE_BIT 0
`define CAC_INT_REJ_BIT 1
`define CAC_INT_EN_RESET 2'h0
`define CAC_RESP_OKAY 2'h0
`define CAC_RESP_SLVERR 2'h2

`endif

// ===== rtl/cac_pkg.sv
// Types shared by both ends of the command acceptance link
package cac_pkg;

  typedef enum logic [2:0] {
    CAC_D_IDLE = 3'b000,
    CAC_D_SAMPLE = 3'b001,
    CAC_D_PARAM = 3'b010,
    CAC_D_REJ = 3'b011,
    CAC_D_REJ_HOLD = 3'b100
  } cac_dev_state_e;

  typedef enum logic [2:0] {
    CAC_H_IDLE = 3'b000,
    CAC_H_READY = 3'b001,
    CAC_H_SAMP = 3'b010,
    CAC_H_WTXR = 3'b011,
    CAC_H_CHK = 3'b100,
    CAC_H_PARAM = 3'b101
  } cac_host_state_e;

  typedef enum logic [1:0] {
    CAC_M_IRQ = 2'b00,
    CAC_M_STR = 2'b01,
    CAC_M_ABORT = 2'b10
  } cac_method_e;

  typedef struct packed {
    logic m_s1;
    logic m_s2;
    cac_dev_state_e st;
    logic [10:0] tmr;
    logic [10:0] a_cnt;
    logic [10:0] b_cnt;
    logic [10:0] arm_cnt;
    logic half;
    logic pend;
    logic irq_n;
    logic [7:0] stat;
    logic [7:0] code;
    logic [7:0] param;
    logic cmd_valid;
    logic sleep_req;
  } cac_dev_s;

  typedef struct packed {
    logic m_s1;
    logic m_s2;
    cac_host_state_e st;
    cac_method_e method;
    logic [7:0] code;
    logic [7:0] param;
    logic [10:0] tmr;
    logic half;
    logic send_abort;
    logic [7:0] retries;
    logic wr_strb;
    logic wr_is_param;
    logic [7:0] wdata;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] int_stat;
    logic [1:0] int_en;
    logic irq;
  } cac_host_s;

endpackage

// ===== tb/cac_props.sv
// Concurrent checks on the command acceptance link, both drive sizes
`timescale 1ns/1ps
`include "cac_map.svh"
module cac_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mode_5in,
  input wire logic wr_strb,
  input wire logic wr_is_param,
  input wire logic [7:0] wdata,
  input wire logic [7:0] main_status_value,
  input wire logic irq_n
);
  logic [10:0] hi_cnt_reg;
  logic [10:0] lo_cnt_reg;
  logic cmd_wr;
  assign cmd_wr = wr_strb && !wr_is_param;
  ////////////////////////////////////////
  // hi_cnt_reg saturates, so a long idle never wraps into a false lead
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_reg <= 11'h000;
      lo_cnt_reg <= 11'h000;
    end else begin
      hi_cnt_reg <= !irq_n ? 11'h000 : hi_cnt_reg + {10'h000, hi_cnt_reg != 11'h7ff};
      lo_cnt_reg <= main_status_value[7] ? 11'h000 : lo_cnt_reg + 11'h001;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_irq_lead: assert property (
    $rose(main_status_value[7]) && irq_n |-> hi_cnt_reg >= 11'd138)
    else $error("interrupt raised too late before request flag");
  a_window_len: assert property (
    $rose(main_status_value[7]) |-> lo_cnt_reg == (mode_5in ? 11'd476 : 11'd238))
    else $error("sampling window length wrong");
  a_cmd_answer: assert property (
    cmd_wr && main_status_value == 8'h80 |=>
      main_status_value == 8'h10 || main_status_value == 8'h00)
    else $error("command write not answered");
  a_reject_irq: assert property (
    main_status_value == 8'h10 && !irq_n |=> !irq_n)
    else $error("interrupt released on rejected command");
  a_reject_tail: assert property (
    !mode_5in && $rose(main_status_value == 8'h90) && !irq_n |->
      ##14 main_status_value == 8'h90 ##1 main_status_value == 8'h80)
    else $error("busy not cleared after rejection hold");
  a_long_reject_tail: assert property (
    mode_5in && $rose(main_status_value == 8'h90) && !irq_n |->
      ##29 main_status_value == 8'h90 ##1 main_status_value == 8'h80)
    else $error("busy not cleared after doubled rejection hold");
  a_half_no_busy: assert property (
    main_status_value == 8'h00 |=> !main_status_value[4])
    else $error("busy shown for half accepted command");
  a_param_done: assert property (
    wr_strb && wr_is_param && main_status_value == 8'h90 |=> main_status_value == 8'h80)
    else $error("parameter write did not end command");
  a_abort_taken: assert property (
    cmd_wr && wdata == `CAC_ABORT_CODE |=> !main_status_value[7])
    else $error("abort not accepted");
endmodule

// ===== tb/tb_top.sv
// Self-checking bench joining controller and host ends
`timescale 1ns/1ps
`include "cac_map.svh"
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic mode_5in, ready_change, seek_done, cmd_valid, sleep_req, irq;
  logic [7:0] cmd_code, cmd_param, awaddr, araddr, lfsr_reg;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [16:0] m_exp;
  logic [16:0] exp_q[$];
  int error_cnt, cmp_count;
  always #20 clk = ~clk;
  cac_link_if cac_link_if_inst (.clk(clk));
  cac_device cac_device_inst (.clk(clk), .resetn(resetn), .mode_5in(mode_5in),
    .ready_change(ready_change), .seek_done(seek_done), .link(cac_link_if_inst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_param(cmd_param), .sleep_req(sleep_req));
  cac_host cac_host_inst (.clk(clk), .resetn(resetn), .mode_5in(mode_5in), .link(cac_link_if_inst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .irq(irq));
  cac_props cac_props_inst (.clk(clk), .resetn(resetn), .mode_5in(mode_5in),
    .wr_strb(cac_link_if_inst.wr_strb),
    .wr_is_param(cac_link_if_inst.wr_is_param), .wdata(cac_link_if_inst.wdata),
    .main_status_value(cac_link_if_inst.main_status_value), .irq_n(cac_link_if_inst.irq_n));
  ////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  // Both channels offered together; each released only when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////
  // Model: queue of commands the controller must hand on, plus retry total
  always @(posedge clk) begin
    if (cmd_valid === 1'b1 && cmd_code !== `CAC_ABORT_CODE) begin
      chk("cmd_pending", 32'h1, {31'h0, exp_q.size() != 0});
      m_exp = exp_q.pop_front();
      chk("cmd_code", {24'h0, m_exp[15:8]}, {24'h0, cmd_code});
      chk("sleep_req", {31'h0, m_exp[16]}, {31'h0, sleep_req});
      if (!m_exp[16]) chk("cmd_param", {24'h0, m_exp[7:0]}, {24'h0, cmd_param});
    end
  end
  task automatic run_cmd(input logic [1:0] m, input logic [7:0] c, input int rt, input logic rj);
    int n;
    lfsr_reg = lfsr_next(lfsr_reg);
    exp_q.push_back({c == `CAC_SLEEP_CODE, c, lfsr_reg});
    axi_wr(`CAC_REG_CTRL, {1'b1, 13'h0, m, lfsr_reg, c}, r);
    n = 0;
    do begin
      axi_rd(`CAC_REG_STATUS, d, r);
      n++;
    end while (d[0] !== 1'b0 && n < 2000);
    repeat (4) @(posedge clk);
    chk("seq_idle", 32'h0, {31'h0, d[0]});
    chk("retries", rt, {24'h0, d[15:8]});
    chk("queue_left", 32'h0, exp_q.size());
    axi_rd(`CAC_REG_INT_STAT, d, r);
    chk("int_stat", {30'h0, rj, 1'b1}, d);
    chk("irq_set", 32'h1, {31'h0, irq});
    axi_wr(`CAC_REG_INT_CLR, 32'h3, r);
    repeat (2) @(posedge clk);
    chk("irq_clear", 32'h0, {31'h0, irq});
  endtask
  task automatic pulse_ready();
    @(posedge clk);
    ready_change <= 1'b1;
    @(posedge clk);
    ready_change <= 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    {mode_5in, ready_change, seek_done, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
    {error_cnt, cmp_count} = {32'h0, 32'h0};
    lfsr_reg = 8'h1c;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    axi_rd(`CAC_REG_INT_EN, d, r);
    chk("int_en_reset", {30'h0, `CAC_INT_EN_RESET}, d);
    axi_wr(`CAC_REG_STATUS, 32'h0, r);
    chk("ro_write", {30'h0, `CAC_RESP_SLVERR}, {30'h0, r});
    axi_rd(8'h20, d, r);
    chk("unmapped", {30'h0, `CAC_RESP_SLVERR}, {30'h0, r});
    axi_wr(`CAC_REG_INT_EN, 32'h3, r);
    axi_rd(`CAC_REG_INT_EN, d, r);
    chk("int_en", 32'h3, d);
    for (int i = 0; i < 3; i++) run_cmd(i[1:0], 8'h05 + i[7:0], 0, 1'b0);
    run_cmd(cac_pkg::CAC_M_IRQ, `CAC_SLEEP_CODE, 0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      pulse_ready();
      run_cmd(i[1:0], 8'h11 + i[7:0], 1, 1'b1);
    end
    pulse_ready();
    repeat (98) @(posedge clk);
    run_cmd(cac_pkg::CAC_M_STR, 8'h22, 0, 1'b0);
    @(posedge clk);
    seek_done <= 1'b1;
    @(posedge clk);
    seek_done <= 1'b0;
    run_cmd(cac_pkg::CAC_M_IRQ, 8'h33, 0, 1'b0);
    // Ready change while pending: long window rejects twice
    @(posedge clk);
    seek_done <= 1'b1;
    @(posedge clk);
    seek_done <= 1'b0;
    pulse_ready();
    run_cmd(cac_pkg::CAC_M_IRQ, 8'h44, 2, 1'b1);
    // Mode changed only while idle; sync needs two edges
    @(posedge clk);
    mode_5in <= 1'b1;
    repeat (4) @(posedge clk);
    pulse_ready();
    run_cmd(cac_pkg::CAC_M_STR, 8'h55, 1, 1'b1);
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule
